// ===== sadu_pkg.sv
// constants and types for the store address and data unit
package sadu_pkg;
    localparam logic [5:0] SADU_OP_STB = 6'h26;
    localparam logic [5:0] SADU_OP_STORE_BYTE_DISP_UPDATE = 6'h27;
    localparam logic [5:0] SADU_OP_STH = 6'h2C;
    localparam logic [5:0] SADU_OP_STHU = 6'h2D;
    localparam logic [5:0] SADU_OP_STORE_MULTIPLE_WORD = 6'h2F;
    localparam logic [5:0] SADU_OP_EXT = 6'h1F;
    localparam logic [9:0] SADU_XO_STORE_BYTE_INDEXED = 10'h0D7;
    localparam logic [9:0] SADU_XO_STBUX = 10'h0F7;
    localparam logic [9:0] SADU_XO_STHX = 10'h197;
    localparam logic [9:0] SADU_XO_STHUX = 10'h1B7;
    localparam logic [9:0] SADU_XO_STHBRX = 10'h396;
    localparam logic [9:0] SADU_XO_STSWI = 10'h2D5;
    localparam logic [5:0] SADU_STRING_MAX = 6'h20;
    localparam logic [4:0] SADU_LAST_GPR = 5'h1F;
    localparam logic [31:0] SADU_WORD_STEP = 32'h00000004;
    localparam logic [31:0] SADU_BYTE_STEP = 32'h00000001;
    typedef enum logic [1:0] {
        SADU_SZ_BYTE,
        SADU_SZ_HALF,
        SADU_SZ_WORD
    } sadu_size_t;
endpackage : sadu_pkg

// ===== sadu_store_unit.sv
// store address and data unit for byte, halfword, multiple and string stores
// What this block does
// - displacement forms sign-extend the 16-bit offset to 32 bits before adding
// - non-update forms use zero base when base selector is zero
// - indexed forms add the full index register to the base
// - update forms use the base register and write the address back
// - byte stores write source bits 24..31 to one byte
// - halfword stores write bits 16..31, more significant byte first
// - byte-reversed halfword writes bits 24..31 first, then 16..23
// - indexed forms with bit 31 set leave compare field zero undefined
// - store-multiple writes source up to register 31 into successive words
// - string store has no displacement; base zero when selector is zero
// - string byte count zero means 32 bytes
// - string emits bytes high first, address plus one, next register per four
// - string register sequence wraps from 31 to 0 until count done
// - string store decodes as primary 31, extended 725
`timescale 1ns/100ps
module sadu_store_unit
    import sadu_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic insn_valid,
    output logic insn_ready,
    input wire logic [31:0] insn,
    output logic [4:0] gpr_rd_sel_a,
    input wire logic [31:0] gpr_rd_data_a,
    output logic [4:0] gpr_rd_sel_b,
    input wire logic [31:0] gpr_rd_data_b,
    output logic [4:0] gpr_rd_sel_c,
    input wire logic [31:0] gpr_rd_data_c,
    output logic gpr_wr_en,
    output logic [4:0] gpr_wr_sel,
    output logic [31:0] gpr_wr_data,
    output logic compare_field_zero_undef,
    output logic invalid_form,
    output logic mem_valid,
    input wire logic mem_ready,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_data,
    output sadu_size_t mem_size,
    output logic busy
);
    logic rst_meta, rst_sync;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    typedef enum logic [1:0] {SADU_IDLE, SADU_SINGLE, SADU_MULTI,
        SADU_STRING} sadu_state_t;
    sadu_state_t state;

    logic [5:0] op;
    logic [9:0] xo;
    logic [4:0] rs_f, ra_f, rb_f;
    logic [31:0] base, offs, ea, src;
    logic is_stb, is_store_byte_disp_update, is_sth, is_sthu, is_store_multiple_word;
    logic is_store_byte_indexed, is_stbux, is_sthx, is_sthux, is_sthbrx, is_stswi;
    logic is_update, is_indexed, is_known;
    assign op = insn[31:26];
    assign rs_f = insn[25:21];
    assign ra_f = insn[20:16];
    assign rb_f = insn[15:11];
    assign xo = insn[10:1];
    assign is_stb = op == SADU_OP_STB;
    assign is_store_byte_disp_update = op == SADU_OP_STORE_BYTE_DISP_UPDATE;
    assign is_sth = op == SADU_OP_STH;
    assign is_sthu = op == SADU_OP_STHU;
    assign is_store_multiple_word = op == SADU_OP_STORE_MULTIPLE_WORD;
    assign is_store_byte_indexed = op == SADU_OP_EXT && xo == SADU_XO_STORE_BYTE_INDEXED;
    assign is_stbux = op == SADU_OP_EXT && xo == SADU_XO_STBUX;
    assign is_sthx = op == SADU_OP_EXT && xo == SADU_XO_STHX;
    assign is_sthux = op == SADU_OP_EXT && xo == SADU_XO_STHUX;
    assign is_sthbrx = op == SADU_OP_EXT && xo == SADU_XO_STHBRX;
    assign is_stswi = op == SADU_OP_EXT && xo == SADU_XO_STSWI;
    assign is_update = is_store_byte_disp_update | is_sthu | is_stbux | is_sthux;
    assign is_indexed = is_store_byte_indexed | is_stbux | is_sthx | is_sthux | is_sthbrx;
    assign is_known = is_update | is_indexed | is_stb | is_sth | is_store_multiple_word
        | is_stswi;

    assign gpr_rd_sel_a = ra_f;
    assign gpr_rd_sel_b = rb_f;
    // update forms always read the register, even selector zero
    assign base = (ra_f == 5'h00 && !is_update) ? 32'h00000000
        : gpr_rd_data_a;
    always_comb begin
        if (is_stswi)
            offs = 32'h00000000;
        else if (is_indexed)
            offs = gpr_rd_data_b;
        else
            offs = {{16{insn[15]}}, insn[15:0]};
    end
    assign ea = base + offs;

    // port c reads one beat ahead so store data can leave a flop
    logic [4:0] cur_reg, next_reg, next_bit;
    logic [1:0] byte_idx, next_idx;
    logic [5:0] left;
    assign next_idx = byte_idx + 2'h1;
    assign next_reg = (state == SADU_STRING && byte_idx != 2'h3) ? cur_reg
        : cur_reg + 5'h01;
    assign next_bit = 5'h1F - {next_idx, 3'h0};
    assign gpr_rd_sel_c = (state == SADU_IDLE) ? rs_f : next_reg;
    assign src = gpr_rd_data_c;

    // data of the beat after the one now offered
    logic [31:0] next_data;
    always_comb begin
        next_data = src;
        if (state == SADU_STRING)
            next_data = {24'h000000, src[next_bit -: 8]};
    end

    logic accept, mem_take;
    assign insn_ready = state == SADU_IDLE;
    assign accept = insn_valid && insn_ready && is_known;
    assign mem_take = mem_valid && mem_ready;
    assign busy = state != SADU_IDLE;

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= SADU_IDLE;
            cur_reg <= 5'h00;
            byte_idx <= 2'h0;
            left <= 6'h00;
        end else begin
            unique case (state)
                SADU_IDLE: if (accept) begin
                    cur_reg <= rs_f;
                    byte_idx <= 2'h0;
                    left <= (insn[15:11] == 5'h00) ? SADU_STRING_MAX
                        : {1'b0, insn[15:11]};
                    if (is_store_multiple_word)
                        state <= SADU_MULTI;
                    else if (is_stswi)
                        state <= SADU_STRING;
                    else
                        state <= SADU_SINGLE;
                end
                SADU_SINGLE: if (mem_take)
                    state <= SADU_IDLE;
                SADU_MULTI: if (mem_take) begin
                    cur_reg <= cur_reg + 5'h01;
                    if (cur_reg == SADU_LAST_GPR)
                        state <= SADU_IDLE;
                end
                SADU_STRING: if (mem_take) begin
                    byte_idx <= byte_idx + 2'h1;
                    left <= left - 6'h01;
                    // 5-bit wrap takes 31 to 0
                    if (byte_idx == 2'h3)
                        cur_reg <= cur_reg + 5'h01;
                    if (left == 6'h01)
                        state <= SADU_IDLE;
                end
            endcase
        end
    end

    // memory request and single-store data
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            mem_valid <= 1'b0;
            mem_addr <= 32'h00000000;
            mem_data <= 32'h00000000;
            mem_size <= SADU_SZ_BYTE;
        end else if (state == SADU_IDLE) begin
            mem_valid <= accept;
            if (accept) begin
                mem_addr <= ea;
                if (is_stb | is_store_byte_disp_update | is_store_byte_indexed | is_stbux) begin
                    mem_size <= SADU_SZ_BYTE;
                    mem_data <= {24'h000000, src[7:0]};
                end else if (is_sthbrx) begin
                    mem_size <= SADU_SZ_HALF;
                    mem_data <= {16'h0000, src[7:0], src[15:8]};
                end else if (is_store_multiple_word) begin
                    mem_size <= SADU_SZ_WORD;
                    mem_data <= src;
                end else if (is_stswi) begin
                    mem_size <= SADU_SZ_BYTE;
                    mem_data <= {24'h000000, src[31:24]};
                end else begin
                    mem_size <= SADU_SZ_HALF;
                    mem_data <= {16'h0000, src[15:0]};
                end
            end
        end else if (state == SADU_SINGLE) begin
            if (mem_take)
                mem_valid <= 1'b0;
        end else begin
            // sequenced modes: present the current register, step on take
            if (mem_take) begin
                mem_addr <= mem_addr + (state == SADU_MULTI ? SADU_WORD_STEP
                    : SADU_BYTE_STEP);
                mem_data <= next_data;
            end
            mem_valid <= !(mem_take && ((state == SADU_MULTI
                && cur_reg == SADU_LAST_GPR)
                || (state == SADU_STRING && left == 6'h01)));
        end
    end

    // write-back only for update forms
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            gpr_wr_en <= 1'b0;
            gpr_wr_sel <= 5'h00;
            gpr_wr_data <= 32'h00000000;
            invalid_form <= 1'b0;
            compare_field_zero_undef <= 1'b0;
        end else begin
            gpr_wr_en <= accept && is_update;
            gpr_wr_sel <= ra_f;
            gpr_wr_data <= ea;
            invalid_form <= accept && is_update && ra_f == 5'h00;
            compare_field_zero_undef <= accept && (is_indexed | is_stswi)
                && insn[0];
        end
    end

    a_update_wb: assert property (@(posedge clk) disable iff (!rst_sync)
        accept && is_update |=> gpr_wr_en && gpr_wr_data == $past(ea))
        else $error("update store did not write back address");
    a_no_side_wr: assert property (@(posedge clk) disable iff (!rst_sync)
        accept && !is_update |=> !gpr_wr_en)
        else $error("non-update store wrote a register");
    a_string_zero: assert property (@(posedge clk) disable iff (!rst_sync)
        accept && is_stswi && insn[15:11] == 5'h00 |=> left == 6'h20)
        else $error("zero byte count not taken as 32");
    a_string_step: assert property (@(posedge clk) disable iff (!rst_sync)
        state == SADU_STRING && mem_take && left != 6'h01
        |=> mem_addr == $past(mem_addr) + 32'h1)
        else $error("string address did not step by one");
    a_multi_step: assert property (@(posedge clk) disable iff (!rst_sync)
        state == SADU_MULTI && mem_take && cur_reg != 5'h1F
        |=> mem_addr == $past(mem_addr) + 32'h4 && mem_valid)
        else $error("multiple address did not step by four");
    a_multi_end: assert property (@(posedge clk) disable iff (!rst_sync)
        state == SADU_MULTI && mem_take && cur_reg == 5'h1F
        |=> state == SADU_IDLE && !mem_valid)
        else $error("multiple did not end after register 31");
    a_string_wrap: assert property (@(posedge clk) disable iff (!rst_sync)
        state == SADU_STRING && mem_take && byte_idx == 2'h3
        && cur_reg == 5'h1F && left != 6'h01 |=> cur_reg == 5'h00)
        else $error("string register did not wrap to zero");
    a_base_zero: assert property (@(posedge clk) disable iff (!rst_sync)
        accept && is_stb && ra_f == 5'h00
        |=> mem_addr == {{16{$past(insn[15])}}, $past(insn[15:0])})
        else $error("zero base not used for selector zero");
endmodule : sadu_store_unit

// ===== sadu_mem_partner.sv
// memory write path model that accepts stores after a set stall
`timescale 1ns/100ps
module sadu_mem_partner (
    input wire logic clk,
    input wire logic mem_valid,
    input wire logic [1:0] stall,
    output logic mem_ready
);
    int cnt;
    initial begin
        mem_ready = 1'b0;
        cnt = 0;
        forever begin
            @(posedge clk);
            #1;
            // ready is a one-cycle pulse, so a stall of zero still costs one
            if (mem_ready) begin
                mem_ready = 1'b0;
                cnt = 0;
            end else if (mem_valid && cnt >= stall) begin
                mem_ready = 1'b1;
            end else if (mem_valid) begin
                cnt++;
            end
        end
    end
endmodule : sadu_mem_partner

// ===== sadu_store_unit_tb.sv
// self-checking bench for the store address and data unit
`timescale 1ns/100ps
module sadu_store_unit_tb;
    import sadu_pkg::*;
    logic clk, resetn, insn_valid, insn_ready, wr_en, busy, cfz, inv;
    logic mem_valid, mem_ready;
    logic [31:0] insn, wr_data, mem_addr, mem_data, r;
    logic [4:0] sel_a, sel_b, sel_c, wr_sel;
    logic [1:0] stall;
    sadu_size_t mem_size;
    logic [31:0] gpr [32];
    logic [65:0] exp_q [$], got_q [$];
    logic [36:0] exp_wb [$], got_wb [$];
    int err_count, n_compared, n_inv, n_cfz, e_inv, e_cfz, j;
    logic [15:0] c;
    logic [15:0] codes [11] = '{{SADU_OP_STB, 10'h0}, {SADU_OP_STORE_BYTE_DISP_UPDATE, 10'h0},
        {SADU_OP_STH, 10'h0}, {SADU_OP_STHU, 10'h0}, {SADU_OP_STORE_MULTIPLE_WORD, 10'h0},
        {SADU_OP_EXT, SADU_XO_STORE_BYTE_INDEXED}, {SADU_OP_EXT, SADU_XO_STBUX},
        {SADU_OP_EXT, SADU_XO_STHX}, {SADU_OP_EXT, SADU_XO_STHUX},
        {SADU_OP_EXT, SADU_XO_STHBRX}, {SADU_OP_EXT, SADU_XO_STSWI}};
    sadu_store_unit u_dut (.clk(clk), .resetn(resetn),
        .insn_valid(insn_valid), .insn_ready(insn_ready), .insn(insn),
        .gpr_rd_sel_a(sel_a), .gpr_rd_data_a(gpr[sel_a]),
        .gpr_rd_sel_b(sel_b), .gpr_rd_data_b(gpr[sel_b]),
        .gpr_rd_sel_c(sel_c), .gpr_rd_data_c(gpr[sel_c]),
        .gpr_wr_en(wr_en), .gpr_wr_sel(wr_sel), .gpr_wr_data(wr_data),
        .compare_field_zero_undef(cfz), .invalid_form(inv),
        .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
        .mem_data(mem_data), .mem_size(mem_size), .busy(busy));
    sadu_mem_partner u_mem (.clk(clk), .mem_valid(mem_valid),
        .stall(stall), .mem_ready(mem_ready));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mem_valid === 1'b1 && mem_ready) got_q.push_back({mem_size,
            mem_addr, mem_data});
        if (wr_en === 1'b1) got_wb.push_back({wr_sel, wr_data});
        if (inv === 1'b1) n_inv++;
        if (cfz === 1'b1) n_cfz++;
    end
    task automatic bad(input string s, input logic [65:0] e, g);
        err_count++;
        $display("MISMATCH %s expected %h seen %h", s, e, g);
    endtask : bad
    task automatic chk_mem(input logic [65:0] e, g);
        n_compared++;
        if (e !== g) bad("store", e, g);
    endtask : chk_mem
    task automatic chk_wb(input logic [36:0] e, g);
        n_compared++;
        if (e !== g) bad("writeback", 66'(e), 66'(g));
    endtask : chk_wb
    task automatic chk_cnt(input string s, input int e, g);
        n_compared++;
        if (e != g) bad(s, 66'(e), 66'(g));
    endtask : chk_cnt
    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic run(input logic [31:0] i);
        logic [5:0] op;
        logic [9:0] xo;
        logic [31:0] rs, base, ea, w;
        logic ext, upd;
        int n, k, s;
        op = i[31:26];
        xo = i[10:1];
        s = i[25:21];
        ext = op == SADU_OP_EXT;
        rs = gpr[s];
        base = i[20:16] == 5'h00 ? 32'h0 : gpr[i[20:16]];
        ea = base + (ext ? gpr[i[15:11]] : {{16{i[15]}}, i[15:0]});
        upd = op inside {SADU_OP_STORE_BYTE_DISP_UPDATE, SADU_OP_STHU} ||
            ext && xo inside {SADU_XO_STBUX, SADU_XO_STHUX};
        e_inv = upd && i[20:16] == 5'h00;
        e_cfz = ext && i[0] && xo inside {SADU_XO_STORE_BYTE_INDEXED, SADU_XO_STBUX,
            SADU_XO_STHX, SADU_XO_STHUX, SADU_XO_STHBRX, SADU_XO_STSWI};
        if (upd && !e_inv) exp_wb.push_back({i[20:16], ea});
        if (op inside {SADU_OP_STB, SADU_OP_STORE_BYTE_DISP_UPDATE} ||
            ext && xo inside {SADU_XO_STORE_BYTE_INDEXED, SADU_XO_STBUX})
            exp_q.push_back({SADU_SZ_BYTE, ea, 24'h0, rs[7:0]});
        if (op inside {SADU_OP_STH, SADU_OP_STHU} ||
            ext && xo inside {SADU_XO_STHX, SADU_XO_STHUX})
            exp_q.push_back({SADU_SZ_HALF, ea, 16'h0, rs[15:0]});
        if (ext && xo == SADU_XO_STHBRX)
            exp_q.push_back({SADU_SZ_HALF, ea, 16'h0, rs[7:0], rs[15:8]});
        for (k = s; op == SADU_OP_STORE_MULTIPLE_WORD && k < 32; k++)
            exp_q.push_back({SADU_SZ_WORD, ea + 32'(4 * (k - s)),
                gpr[k]});
        n = i[15:11] == 5'h00 ? 32 : int'(i[15:11]);
        for (k = 0; ext && xo == SADU_XO_STSWI && k < n; k++) begin
            w = gpr[5'(s + k / 4)];
            exp_q.push_back({SADU_SZ_BYTE, base + 32'(k), 24'h0,
                w[31 - 8 * (k % 4) -: 8]});
        end
        insn = i;
        insn_valid = 1'b1;
        @(posedge clk);
        #1 insn_valid = 1'b0;
        for (k = 0; busy !== 1'b0 && k < 400; k++) @(posedge clk) #1;
        if (k == 400) bad("completion", 66'h0, 66'h1);
        if (k == 400) conclude;
        repeat (2) @(posedge clk);
        #1;
        chk_cnt("invalid flag", e_inv, n_inv);
        chk_cnt("undefined field flag", e_cfz, n_cfz);
        if (!e_inv) begin
            chk_cnt("store count", exp_q.size(), got_q.size());
            chk_cnt("writeback count", exp_wb.size(), got_wb.size());
            while (exp_q.size() > 0 && got_q.size() > 0)
                chk_mem(exp_q.pop_front(), got_q.pop_front());
            while (exp_wb.size() > 0 && got_wb.size() > 0)
                chk_wb(exp_wb.pop_front(), got_wb.pop_front());
        end
        exp_q.delete();
        got_q.delete();
        exp_wb.delete();
        got_wb.delete();
        n_inv = 0;
        n_cfz = 0;
    endtask : run
    initial begin
        void'($urandom(32'hCFBDF903));
        {resetn, insn_valid, insn, stall, err_count, n_compared} = '0;
        foreach (gpr[k]) gpr[k] = $urandom;
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        run({SADU_OP_STB, 5'h03, 5'h04, 16'h8000});
        run({SADU_OP_STB, 5'h03, 5'h00, 16'h7FFF});
        run({SADU_OP_STHU, 5'h05, 5'h00, 16'h0010});
        stall = 2'h3;
        run({SADU_OP_STORE_MULTIPLE_WORD, 5'h1D, 5'h02, 16'hFFF0});
        run({SADU_OP_EXT, 5'h1E, 5'h00, 5'h00, SADU_XO_STSWI, 1'b1});
        run({SADU_OP_EXT, 5'h01, 5'h02, 5'h03, 10'h295, 1'b1});
        for (j = 0; j < 40; j++) begin
            stall = 2'($urandom);
            c = codes[$urandom_range(10)];
            r = $urandom;
            run(c[15:10] == SADU_OP_EXT ? {c[15:10], r[25:11], c[9:0], r[0]}
                : {c[15:10], r[25:0]});
        end
        conclude;
    end
endmodule : sadu_store_unit_tb
